/* File: rtl/osd_pkg.sv */
// Shared constants for the on-screen-display serial port and reset block
`default_nettype none
package osd_pkg;
	// Timing, in the units as printed, and the derived cycle counts
	localparam int CLK_MHZ = 200;
	localparam int SCLK_MAX_MHZ = 10;
	localparam int REG_RESET_US = 100;
	localparam int DM_CLEAR_US = 20;
	localparam int POR_MS = 50;
	localparam int REG_RESET_CYCLES = REG_RESET_US * CLK_MHZ;
	localparam int DM_CLEAR_CYCLES = DM_CLEAR_US * CLK_MHZ;
	localparam int POR_CYCLES = POR_MS * 1000 * CLK_MHZ;
	localparam int SCLK_MIN_CYCLES = CLK_MHZ / SCLK_MAX_MHZ;

	// Register indices below 20H and the black level address
	localparam logic [4:0] IDX_VM0 = 5'h00;
	localparam logic [4:0] IDX_DMM = 5'h04;
	localparam logic [4:0] IDX_DMAH = 5'h05;
	localparam logic [4:0] IDX_DMAL = 5'h06;
	localparam logic [4:0] IDX_DMDI = 5'h07;
	localparam logic [4:0] IDX_CMDI = 5'h0b;
	localparam logic [4:0] IDX_INSERTION_MUX_CONTROL = 5'h0c;
	localparam logic [7:0] ADDR_BLACK = 8'h6c;

	// Read side: top nibble of special read addresses
	localparam int READ_BIT = 7;
	localparam logic [3:0] RD_STATUS = 4'ha;
	localparam logic [3:0] RD_DISPLAY = 4'hb;
	localparam logic [3:0] RD_GLYPH = 4'hc;

	// Field positions
	localparam int VM0_SWRST_BIT = 1;
	localparam int VM0_OSD_EN_BIT = 3;
	localparam int DMM_AUTO_BIT = 0;
	localparam int DMM_CLEAR_BIT = 2;
	localparam int DMM_ATTR_LSB = 3;
	localparam int DMM_MODE8_BIT = 6;
	localparam int DMAH_ATTR_BIT = 1;
	localparam int DMAH_HIGH_BIT = 0;
	localparam int INSERTION_MUX_CONTROL_EDGE_LSB = 3;
	localparam int INSERTION_MUX_CONTROL_MUX_LSB = 0;
	localparam int STAT_DONE_BIT = 6;
	localparam int STAT_GLYPH_BUSY_BIT = 5;

	// Reset values and codes
	localparam logic [7:0] REG_DEFAULT = 8'h00;
	localparam logic [7:0] BLACK_DEFAULT = 8'h00;
	localparam logic [7:0] AUTO_EXIT = 8'hff;
	localparam logic [15:0] DM_CLEAR_WORD = 16'h0000;

	// Frame lengths in serial clocks
	localparam logic [4:0] LEN_AUTO = 5'h08;
	localparam logic [4:0] LEN_WORD = 5'h10;
	localparam logic [4:0] LEN_LONG = 5'h18;
	localparam logic [4:0] LEN_FIRST = 5'h07;
	localparam logic [4:0] LEN_SAT = 5'h1f;
endpackage
`default_nettype wire

/* File: rtl/osd_serial_port_and_reset.sv */
// Serial command port, frame buffer and reset sequencing of the OSD generator
// Functional notes
// - Serial clock up to 10MHz accepted; host stays at or below it.
// - Chip select low frames a transfer; clock and data ignored while high.
// - Serial data sampled on each serial clock rising edge.
// - A write reaches the registers only when chip select rises after completion.
// - Chip select rising early abandons the frame, registers unchanged.
// - Outside auto-increment mode the first byte decides the kind and length of the frame.
// - Normal frame: 16 bits, address byte then data byte.
// - Auto-increment frame: data byte only, address kept internally.
// - 16-bit mode display read: 24 bits, address then 16 data bits.
// - Reads return written registers, status, display and glyph readback.
// - Read address equals write address with top bit set.
// - Power-on reset restores defaults and clears display memory.
// - Register reset lasts 100us; up to eight writes meanwhile wait in the buffer and are applied after it.
// - Power-on clearing and register reset finish after about 50ms.
// - Status bit 6 reports the reset sequence finished.
// - Software reset bit clears memory, restores registers except black level.
// - Software reset completes in about 100us, then status reports done.
// - Hardware reset low holds defaults and refuses accesses.
// - Registers restored within 100us after hardware reset rises.
// - Display memory all zero within 20us after hardware reset rises.
// - Hardware reset wins over the software reset bit.
// - Edge time and mux switching time come from the insertion mux control.
`default_nettype none

module frame_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic flush,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} fifo_state_t;
	fifo_state_t s, n;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;

	assign full = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
	assign in_ready = !full && !flush;
	assign out_valid = (s.wr != s.rd);
	assign out_data = mem[s.rd[AW-1:0]];

	always_comb begin
		n = s;
		if (in_valid && in_ready) begin
			n.wr = s.wr + 1'b1;
		end
		if (out_valid && out_ready) begin
			n.rd = s.rd + 1'b1;
		end
		if (flush) begin
			n = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (in_valid && in_ready) begin
			mem[s.wr[AW-1:0]] <= in_data;
		end
	end
endmodule

module osd_serial_port_and_reset #(
	parameter int POR_CYCLES = osd_pkg::POR_CYCLES,
	parameter int REG_RESET_CYCLES = osd_pkg::REG_RESET_CYCLES,
	parameter int DM_DEPTH = 512,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdin,
	output var logic sdout,
	output var logic sdout_en,
	// Hardware reset pin
	input wire logic hw_reset_n,
	// Settings to the video path
	output logic reset_done,
	output logic osd_enable,
	output logic [2:0] osd_edge_time,
	output logic [2:0] mux_switch_time,
	output logic [7:0] black_level,
	// Frame buffer can take another write
	output logic frame_buffer_ready
);
	localparam int FW = 17;
	localparam int DAW = $clog2(DM_DEPTH);

	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] sclk_s;
		logic [1:0] sdin_s;
		logic [2:0] hrst_s;
		logic [23:0] rx;
		logic [4:0] bits;
		logic [4:0] len;
		logic is_read;
		logic [15:0] tx;
		logic sdout;
		logic sdout_en;
		logic [31:0][7:0] regs;
		logic [7:0] black;
		logic busy;
		logic [23:0] cnt;
		logic clr;
		logic [DAW-1:0] clr_idx;
	} state_t;

	state_t s, n;
	logic [15:0] dmem [DM_DEPTH];
	logic mem_we;
	logic [DAW-1:0] mem_addr;
	logic [15:0] mem_wdata;
	logic cs_low, cs_rise, sclk_rise, sclk_fall, hrst_ok;
	logic push, pop, fifo_in_ready, fifo_out_valid;
	logic [FW-1:0] push_data, fifo_out;

	assign cs_low = !s.cs_s[1];
	assign cs_rise = s.cs_s[1] && !s.cs_s[2];
	// at 10MHz each serial half period spans ten system clocks
	assign sclk_rise = s.sclk_s[1] && !s.sclk_s[2];
	assign sclk_fall = !s.sclk_s[1] && s.sclk_s[2];
	assign hrst_ok = s.hrst_s[1];
	// Writes wait in the buffer while a reset or clear runs
	assign pop = fifo_out_valid && !s.busy && !s.clr && hrst_ok;
	assign frame_buffer_ready = fifo_in_ready;

	frame_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) write_buffer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.flush(!hrst_ok),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out)
	);

	always_comb begin
		logic [7:0] first;
		logic [7:0] st;
		logic [7:0] display_memory_mode_register;
		logic [DAW-1:0] dma;
		logic [15:0] dmw;
		logic [15:0] rdv;
		logic [7:0] wa;
		logic [7:0] wd;
		logic [DAW-1:0] dnext;
		first = {s.rx[6:0], s.sdin_s[1]};
		st = 8'h00;
		display_memory_mode_register = s.regs[osd_pkg::IDX_DMM];
		dma = DAW'({s.regs[osd_pkg::IDX_DMAH][osd_pkg::DMAH_HIGH_BIT],
			s.regs[osd_pkg::IDX_DMAL]});
		dmw = dmem[dma];
		rdv = 16'h0000;
		wa = fifo_out[15:8];
		wd = fifo_out[7:0];
		dnext = dma + 1'b1;
		n = s;
		mem_we = 1'b0;
		mem_addr = '0;
		mem_wdata = osd_pkg::DM_CLEAR_WORD;
		n.cs_s = {s.cs_s[1:0], cs_n};
		n.sclk_s = {s.sclk_s[1:0], sclk};
		n.sdin_s = {s.sdin_s[0], sdin};
		n.hrst_s = {s.hrst_s[1:0], hw_reset_n};

		// Read value chosen from the first byte
		st[osd_pkg::STAT_DONE_BIT] = !s.busy && !s.clr;
		st[osd_pkg::STAT_GLYPH_BUSY_BIT] = 1'b0;
		if (first[7:4] == osd_pkg::RD_STATUS) begin
			rdv = {st, 8'h00};
		end else if (first[7:4] == osd_pkg::RD_DISPLAY) begin
			if (!display_memory_mode_register[osd_pkg::DMM_MODE8_BIT]) begin
				rdv = dmw;
			end else if (s.regs[osd_pkg::IDX_DMAH][osd_pkg::DMAH_ATTR_BIT]) begin
				rdv = {dmw[7:0], 8'h00};
			end else begin
				rdv = {dmw[15:8], 8'h00};
			end
		end else if (first[7:4] == osd_pkg::RD_GLYPH) begin
			rdv = {s.regs[osd_pkg::IDX_CMDI], 8'h00};
		end else if (first[6:5] == 2'b00) begin
			rdv = {s.regs[first[4:0]], 8'h00};
		end else if ({1'b0, first[6:0]} == osd_pkg::ADDR_BLACK) begin
			rdv = {s.black, 8'h00};
		end

		// Serial shifter
		if (!cs_low) begin
			n.bits = 5'h00;
			n.is_read = 1'b0;
			n.sdout_en = 1'b0;
		end else begin
			if (sclk_rise) begin
				n.rx = {s.rx[22:0], s.sdin_s[1]};
				if (s.bits != osd_pkg::LEN_SAT) begin
					n.bits = s.bits + 5'h01;
				end
				if (s.bits == osd_pkg::LEN_FIRST) begin
					if (display_memory_mode_register[osd_pkg::DMM_AUTO_BIT]) begin
						n.len = osd_pkg::LEN_AUTO;
						n.is_read = 1'b0;
					end else if (first[osd_pkg::READ_BIT]) begin
						n.is_read = 1'b1;
						n.tx = rdv;
						if (first[7:4] == osd_pkg::RD_DISPLAY &&
							!display_memory_mode_register[osd_pkg::DMM_MODE8_BIT]) begin
							n.len = osd_pkg::LEN_LONG;
						end else begin
							n.len = osd_pkg::LEN_WORD;
						end
					end else begin
						n.len = osd_pkg::LEN_WORD;
						n.is_read = 1'b0;
					end
				end
			end
			if (sclk_fall && s.is_read && s.bits >= osd_pkg::LEN_AUTO) begin
				n.sdout = s.tx[15];
				n.tx = {s.tx[14:0], 1'b0};
				n.sdout_en = 1'b1;
			end
		end

		// Commit only a whole write frame; a short one is dropped
		push = cs_rise && s.bits == s.len && !s.is_read &&
			s.len != 5'h00 && hrst_ok;
		push_data = {s.len == osd_pkg::LEN_AUTO, s.rx[15:0]};

		// Apply buffered writes
		if (pop) begin
			if (fifo_out[16]) begin
				if (wd == osd_pkg::AUTO_EXIT) begin
					n.regs[osd_pkg::IDX_DMM][osd_pkg::DMM_AUTO_BIT] = 1'b0;
				end else begin
					mem_we = 1'b1;
					mem_addr = dma;
					mem_wdata = {wd, dmw[7:0]};
					n.regs[osd_pkg::IDX_DMAL] = dnext[7:0];
					n.regs[osd_pkg::IDX_DMAH][osd_pkg::DMAH_HIGH_BIT] =
						dnext[DAW-1];
				end
			end else if (wa == {3'h0, osd_pkg::IDX_VM0} &&
				wd[osd_pkg::VM0_SWRST_BIT]) begin
				n.regs = {32{osd_pkg::REG_DEFAULT}};
				n.clr = 1'b1;
				n.clr_idx = '0;
				n.busy = 1'b1;
				n.cnt = 24'(REG_RESET_CYCLES - 1);
			end else if (wa == {3'h0, osd_pkg::IDX_DMDI}) begin
				mem_we = 1'b1;
				mem_addr = dma;
				if (!display_memory_mode_register[osd_pkg::DMM_MODE8_BIT]) begin
					mem_wdata = {wd, 5'h00, display_memory_mode_register[osd_pkg::DMM_ATTR_LSB +: 3]};
				end else if (s.regs[osd_pkg::IDX_DMAH][osd_pkg::DMAH_ATTR_BIT]) begin
					mem_wdata = {dmw[15:8], wd};
				end else begin
					mem_wdata = {wd, dmw[7:0]};
				end
			end else if (wa == osd_pkg::ADDR_BLACK) begin
				n.black = wd;
			end else if (wa[7:5] == 3'h0) begin
				n.regs[wa[4:0]] = wd;
				if (wa == {3'h0, osd_pkg::IDX_DMM} &&
					wd[osd_pkg::DMM_CLEAR_BIT]) begin
					n.clr = 1'b1;
					n.clr_idx = '0;
				end
			end
		end

		// Display memory clear walker, one word a cycle
		if (s.clr && hrst_ok) begin
			mem_we = 1'b1;
			mem_addr = s.clr_idx;
			mem_wdata = osd_pkg::DM_CLEAR_WORD;
			n.clr_idx = s.clr_idx + 1'b1;
			if (s.clr_idx == DAW'(DM_DEPTH - 1)) begin
				n.clr = 1'b0;
				n.regs[osd_pkg::IDX_DMM][osd_pkg::DMM_CLEAR_BIT] = 1'b0;
			end
		end

		// Reset sequence timer
		if (s.busy && hrst_ok) begin
			if (s.cnt == 24'h00_0000) begin
				n.busy = 1'b0;
			end else begin
				n.cnt = s.cnt - 24'h00_0001;
			end
		end

		// Hardware reset last so that it overrides a software reset
		if (!hrst_ok) begin
			n.regs = {32{osd_pkg::REG_DEFAULT}};
			n.black = osd_pkg::BLACK_DEFAULT;
			n.busy = 1'b1;
			n.cnt = 24'(REG_RESET_CYCLES - 1);
			n.clr = 1'b1;
			n.clr_idx = '0;
			n.bits = 5'h00;
			n.is_read = 1'b0;
			n.sdout_en = 1'b0;
			mem_we = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.cs_s <= 3'h7;
			// Pin idles high; a zero here would fake a hardware reset
			s.hrst_s <= 3'h7;
			s.regs <= {32{osd_pkg::REG_DEFAULT}};
			s.black <= osd_pkg::BLACK_DEFAULT;
			s.busy <= 1'b1;
			s.cnt <= 24'(POR_CYCLES - 1);
			s.clr <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Memory holds no reset; the clear walker zeroes it instead
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			dmem[mem_addr] <= mem_wdata;
		end
	end

	assign sdout = s.sdout;
	assign sdout_en = s.sdout_en;
	assign reset_done = !s.busy && !s.clr;
	assign osd_enable = s.regs[osd_pkg::IDX_VM0][osd_pkg::VM0_OSD_EN_BIT];
	assign osd_edge_time =
		s.regs[osd_pkg::IDX_INSERTION_MUX_CONTROL][osd_pkg::INSERTION_MUX_CONTROL_EDGE_LSB +: 3];
	assign mux_switch_time =
		s.regs[osd_pkg::IDX_INSERTION_MUX_CONTROL][osd_pkg::INSERTION_MUX_CONTROL_MUX_LSB +: 3];
	assign black_level = s.black;

	cs_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!cs_low |=> s.bits == 5'h00)
		else $error("bit count kept while chip select high");
	sample_edge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		sclk_rise && cs_low && hrst_ok |=> s.rx[0] == $past(s.sdin_s[1]))
		else $error("serial data not sampled on rising edge");
	commit_end_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		push |-> cs_rise && s.bits == s.len && !s.is_read)
		else $error("write committed outside frame end");
	abort_short_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		cs_rise && s.bits != s.len |-> !push)
		else $error("short frame was committed");
	decode_kind_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		sclk_rise && cs_low && hrst_ok && s.bits == 5'h07 &&
		!s.regs[osd_pkg::IDX_DMM][osd_pkg::DMM_AUTO_BIT]
		|=> s.is_read == $past(s.rx[6]) && s.len >= 5'h10)
		else $error("first byte decoded wrongly");
	auto_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		sclk_rise && cs_low && hrst_ok && s.bits == 5'h07 &&
		s.regs[osd_pkg::IDX_DMM][osd_pkg::DMM_AUTO_BIT]
		|=> s.len == 5'h08 && !s.is_read)
		else $error("auto-increment frame not eight bits");
	read_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		sclk_fall && cs_low && hrst_ok && s.is_read && s.bits >= 5'h08
		|=> s.sdout == $past(s.tx[15]) && s.sdout_en)
		else $error("read bit not driven on falling edge");
	sw_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		pop && hrst_ok && !fifo_out[16] && fifo_out[15:8] == 8'h00 &&
		fifo_out[1] |=> s.clr && s.busy && s.black == $past(s.black))
		else $error("software reset did not start correctly");
	hw_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!hrst_ok |=> s.busy && s.clr &&
		s.cnt == 24'(REG_RESET_CYCLES - 1) && s.black == 8'h00)
		else $error("hardware reset did not hold defaults");
	hw_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		s.hrst_s[1] && !s.hrst_s[2] |-> ##[1:600] !s.clr)
		else $error("display memory not cleared in time");
endmodule
`default_nettype wire

/* File: tb/osd_host_model.sv */
// Behavioural host that clocks serial frames into the OSD block
`default_nettype none
module osd_host_model #(
	parameter int HALF_NS = 51
) (
	// Serial pins
	output var logic cs_n,
	output var logic sclk,
	output var logic sdin,
	input wire logic sdout
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdin = 1'b1;
	end

	// Half period kept off the 5ns grid so edges drift against sys_clk
	task automatic xfer(input int n, input logic [23:0] tx,
		output logic [23:0] rx);
		rx = 24'h00_0000;
		cs_n = 1'b0;
		#(HALF_NS);
		for (int i = n - 1; i >= 0; i--) begin
			sdin = tx[i];
			#(HALF_NS);
			sclk = 1'b1;
			rx = {rx[22:0], sdout};
			#(HALF_NS);
			sclk = 1'b0;
		end
		#(HALF_NS);
		cs_n = 1'b1;
		// A released line must not keep showing the last bit
		sdin = ~sdin;
		#(2 * HALF_NS);
	endtask
endmodule
`default_nettype wire

/* File: tb/osd_serial_port_and_reset_tb_top.sv */
// Self-checking bench for the OSD serial port and reset block
`default_nettype none
module osd_serial_port_and_reset_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int POR_SIM = 4000;
	localparam int REG_SIM = 100;
	logic sys_clk, resetn, hw_reset_n;
	logic cs_n, sclk, sdin, sdout, sdout_en, reset_done, osd_enable;
	logic frame_buffer_ready;
	logic [2:0] osd_edge_time, mux_switch_time;
	logic [7:0] black_level, v;
	logic [23:0] rx;
	int fail_count = 0;
	int samples_checked = 0;

	osd_serial_port_and_reset #(
		.POR_CYCLES(POR_SIM),
		.REG_RESET_CYCLES(REG_SIM)
	) uut (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.cs_n(cs_n),
		.sclk(sclk),
		.sdin(sdin),
		.sdout(sdout),
		.sdout_en(sdout_en),
		.hw_reset_n(hw_reset_n),
		.reset_done(reset_done),
		.osd_enable(osd_enable),
		.osd_edge_time(osd_edge_time),
		.mux_switch_time(mux_switch_time),
		.black_level(black_level),
		.frame_buffer_ready(frame_buffer_ready)
	);

	osd_host_model host (
		.cs_n(cs_n),
		.sclk(sclk),
		.sdin(sdin),
		.sdout(sdout)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(16, {8'h00, a, d}, rx);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		host.xfer(16, {8'h00, a, 8'h00}, rx);
		d = rx[7:0];
	endtask

	task automatic wait_done(input int limit);
		for (int i = 0; i < limit && reset_done !== 1'b1; i++)
			@(posedge sys_clk);
		check(reset_done, 1'b1);
		rd(8'ha0, v);
		check(v[6], 1'b1);
	endtask

	task automatic test_por_fill();
		check(reset_done, 1'b0);
		// Writes queue while the power-on sequence is still busy
		for (int i = 0; i < 8; i++)
			wr(8'h10 + 8'(i), 8'h30 + 8'(i));
		repeat (8) @(posedge sys_clk);
		check(frame_buffer_ready, 1'b0);
		wait_done(POR_SIM + 1000);
		rd(8'h97, v);
		check(v, 8'h37);
		rd(8'h90, v);
		check(v, 8'h30);
		check(black_level, 8'h00);
		$display("test_por_fill finished");
	endtask

	task automatic test_write_read();
		wr(8'h0c, 8'h1a);
		wr(8'h6c, 8'h5a);
		wr(8'h00, 8'h08);
		rd(8'h8c, v);
		check(v, 8'h1a);
		check(osd_edge_time, 3'h3);
		check(mux_switch_time, 3'h2);
		check(black_level, 8'h5a);
		check(osd_enable, 1'b1);
		rd(8'hec, v);
		check(v, 8'h5a);
		rd(8'hf0, v);
		check(v, 8'h00);
		$display("test_write_read finished");
	endtask

	task automatic test_abort();
		host.xfer(12, 24'h00_00c7, rx);
		check(sdout_en, 1'b0);
		rd(8'h8c, v);
		check(v, 8'h1a);
		check(mux_switch_time, 3'h2);
		$display("test_abort finished");
	endtask

	task automatic test_display();
		wr(8'h05, 8'h00);
		wr(8'h06, 8'h10);
		wr(8'h07, 8'h41);
		host.xfer(24, 24'hb0_0000, rx);
		check(rx[15:0], 16'h4100);
		wr(8'h06, 8'h11);
		wr(8'h04, 8'h01);
		host.xfer(8, 24'h00_0042, rx);
		host.xfer(8, 24'h00_00ff, rx);
		wr(8'h06, 8'h11);
		host.xfer(24, 24'hb0_0000, rx);
		check(rx[15:0], 16'h4200);
		$display("test_display finished");
	endtask

	task automatic test_swreset();
		wr(8'h00, 8'h02);
		check(reset_done, 1'b0);
		wait_done(REG_SIM + 1000);
		check(osd_enable, 1'b0);
		check(mux_switch_time, 3'h0);
		check(black_level, 8'h5a);
		wr(8'h06, 8'h11);
		host.xfer(24, 24'hb0_0000, rx);
		check(rx[15:0], 16'h0000);
		$display("test_swreset finished");
	endtask

	task automatic test_hwreset();
		wr(8'h0c, 8'h1a);
		wr(8'h07, 8'h55);
		hw_reset_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		check(frame_buffer_ready, 1'b0);
		check(black_level, 8'h00);
		// Deliberately ignores the quiet pulse to prove refusal
		wr(8'h0c, 8'h3f);
		wr(8'h00, 8'h02);
		@(posedge sys_clk);
		hw_reset_n <= 1'b1;
		wait_done(REG_SIM + 1000);
		check(mux_switch_time, 3'h0);
		wr(8'h06, 8'h11);
		host.xfer(24, 24'hb0_0000, rx);
		check(rx[15:0], 16'h0000);
		$display("test_hwreset finished");
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		fail_count++;
		print_verdict();
	end

	initial begin
		resetn = 1'b0;
		hw_reset_n = 1'b1;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		test_por_fill();
		test_write_read();
		test_abort();
		test_display();
		test_swreset();
		test_hwreset();
		print_verdict();
	end
endmodule
`default_nettype wire
